// ==== hw/mfh_fifo.sv ====
// small fifo with registered head word and registered full flag
`timescale 1ns/100ps
module mfh_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH+2)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam int LW = $clog2(DEPTH+2);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic push;
  logic load;

  assign push = in_valid_i && in_ready_o;
  assign load = (cnt != '0) && (!out_valid_o || out_ready_i);
  assign level_o = LW'(cnt) + LW'(out_valid_o);

  always_comb begin
    next_cnt = cnt;
    if (push && !load) begin
      next_cnt = cnt + CW'(1);
    end else if (load && !push) begin
      next_cnt = cnt - CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage and pointers
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      in_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wptr <= wptr + AW'(1);
      end
      if (load) begin
        rptr <= rptr + AW'(1);
      end
      cnt <= next_cnt;
      in_ready_o <= (next_cnt != CW'(DEPTH));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // head register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (ce_i) begin
      if (load) begin
        out_valid_o <= 1'b1;
        out_data_o <= mem[rptr];
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule

// ==== hw/mfh_host_port.sv ====
// host side fifo access port for four ethernet ports
//
// Summary of operation
// R1: tx space flag high when free slots reach the tx threshold.
// R2: tx space flags driven only while tx side enable is low.
// R3: rx data flag high at rx threshold or when a whole frame is held.
// R4: rx data flags driven only while rx side enable is low.
// R5: qualifier marks valid read words and free space for writes.
// R6: frame end marker driven out on reads, high on a frame's last word.
// R7: host raises frame end marker with the last written word.
// R8: frame end stored as word bit 32; rx bit 32 returned on reads.
// R9: per-frame skip fcs input held anytime in a frame drops its crc.
// R10: global no fcs bit drops the crc of every frame.
// R11: data bus driven only when rx enable and rx read gate are low.
// R12: one word moves per qualified rising strobe edge.
// R13: port select 00..11 chooses ports 1..4.
// R14: low byte lane enables mark valid written and driven read bytes.
// R15: host supplies a continuous strobe clock within rated speed.
// R16: writes to a full tx fifo ignored; empty rx fifo not popped.
// R17: ready flags recomputed every clock against register thresholds.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module mfh_host_port
  import mfh_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic tx_side_enable_n_i,
  input wire logic rx_side_enable_n_i,
  input wire logic rx_read_gate_n_i,
  input wire logic rx_fifo_read_gate_n_i,
  input wire logic tx_fifo_write_gate_n_i,
  input wire logic fifo_strobe_clock_i,
  input wire logic [1:0] fifo_port_select_i,
  input wire logic [3:0] byte_lane_enable_n_i,
  input wire logic skip_fcs_this_frame_i,
  input wire logic [31:0] fifo_data_i,
  output logic [31:0] fifo_data_o,
  output logic [3:0] fifo_data_oe_o,
  input wire logic frame_end_marker_i,
  output logic frame_end_marker_o,
  output logic frame_end_marker_oe_o,
  output logic [3:0] tx_space_flag_o,
  output logic tx_space_flag_oe_o,
  output logic [3:0] rx_data_flag_o,
  output logic rx_data_flag_oe_o,
  output logic space_or_data_valid_o,
  output logic [127:0] mac_tx_data_o,
  output logic [3:0] mac_tx_eof_o,
  output logic [3:0] mac_tx_no_fcs_o,
  output logic [3:0] mac_tx_valid_o,
  input wire logic [3:0] mac_tx_ready_i,
  input wire logic [127:0] mac_rx_data_i,
  input wire logic [3:0] mac_rx_eof_i,
  input wire logic [3:0] mac_rx_valid_i,
  output logic [3:0] mac_rx_ready_o
);
  logic global_no_fcs;
  logic [LVL_W-1:0] thr_tx;
  logic [LVL_W-1:0] thr_rx;
  logic strobe_prev;
  logic strobe_rise;
  logic host_wr;
  logic host_rd;
  logic [DATA_W-1:0] wr_masked;
  logic [DATA_W-1:0] rd_masked;
  logic [3:0] frame_skip;
  logic [3:0] tx_push;
  logic [3:0] rx_pop;
  logic [3:0] tx_in_ready;
  logic [3:0] rx_out_valid;
  logic [RX_W-1:0] rx_out_data [NUM_PORTS];
  logic [LVL_W-1:0] tx_level [NUM_PORTS];
  logic [LVL_W-1:0] rx_level [NUM_PORTS];
  logic [LVL_W-1:0] rx_frames [NUM_PORTS];
  logic [TX_W-1:0] tx_word;
  logic [RX_W-1:0] sel_rx_data;
  logic [31:0] next_prdata;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // strobe qualification
  assign strobe_rise = fifo_strobe_clock_i && !strobe_prev;
  assign host_wr = strobe_rise && !tx_side_enable_n_i && !tx_fifo_write_gate_n_i; // see R12
  assign host_rd = strobe_rise && !rx_side_enable_n_i && !rx_fifo_read_gate_n_i; // see R12
  assign sel_rx_data = rx_out_data[fifo_port_select_i]; // see R13

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_prev <= 1'b0;
    end else if (clk_en_i) begin
      strobe_prev <= fifo_strobe_clock_i;
    end
  end

  // byte lane masking
  always_comb begin
    wr_masked = '0;
    rd_masked = '0;
    for (int b = 0; b < 4; b++) begin
      if (!byte_lane_enable_n_i[b]) begin
        wr_masked[8*b +: 8] = fifo_data_i[8*b +: 8]; // see R14
        rd_masked[8*b +: 8] = sel_rx_data[8*b +: 8]; // see R14
      end
    end
  end

  // crc drop stored with each word, used at the frame end
  assign tx_word = {global_no_fcs || frame_skip[fifo_port_select_i] || skip_fcs_this_frame_i, // see R9 R10
                    frame_end_marker_i, wr_masked}; // see R8

  ////////////////////////////////////////////////////////////////////////
  // per port fifos
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign tx_push[p] = host_wr && (fifo_port_select_i == 2'(p)); // see R13
    assign rx_pop[p] = host_rd && (fifo_port_select_i == 2'(p)) && rx_out_valid[p]; // see R16

    mfh_fifo #(.W(TX_W), .DEPTH(FIFO_DEPTH)) u_tx (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(clk_en_i),
      .in_valid_i(tx_push[p]),
      .in_data_i(tx_word),
      .in_ready_o(tx_in_ready[p]),
      .out_valid_o(mac_tx_valid_o[p]),
      .out_data_o({mac_tx_no_fcs_o[p], mac_tx_eof_o[p], mac_tx_data_o[32*p +: 32]}),
      .out_ready_i(mac_tx_ready_i[p]),
      .level_o(tx_level[p])
    );

    mfh_fifo #(.W(RX_W), .DEPTH(FIFO_DEPTH)) u_rx (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(clk_en_i),
      .in_valid_i(mac_rx_valid_i[p]),
      .in_data_i({mac_rx_eof_i[p], mac_rx_data_i[32*p +: 32]}),
      .in_ready_o(mac_rx_ready_o[p]),
      .out_valid_o(rx_out_valid[p]),
      .out_data_o(rx_out_data[p]),
      .out_ready_i(rx_pop[p]),
      .level_o(rx_level[p])
    );

    // whole frames held in the rx fifo
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        rx_frames[p] <= '0;
      end else if (clk_en_i) begin
        rx_frames[p] <= rx_frames[p]
                      + LVL_W'(mac_rx_valid_i[p] && mac_rx_ready_o[p] && mac_rx_eof_i[p])
                      - LVL_W'(rx_pop[p] && rx_out_data[p][EOF_BIT]); // see R3
      end
    end

    // per frame crc drop, sticky until the frame end word
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        frame_skip[p] <= 1'b0;
      end else if (clk_en_i && tx_push[p] && tx_in_ready[p]) begin
        frame_skip[p] <= !frame_end_marker_i && (frame_skip[p] || skip_fcs_this_frame_i); // see R9
      end
    end

    // tx ready flag
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        tx_space_flag_o[p] <= 1'b0;
      end else if (clk_en_i) begin
        tx_space_flag_o[p] <= (FIFO_SLOTS - tx_level[p]) >= thr_tx; // see R1 R17
      end
    end

    // rx ready flag
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        rx_data_flag_o[p] <= 1'b0;
      end else if (clk_en_i) begin
        rx_data_flag_o[p] <= (rx_level[p] >= thr_rx) || (rx_frames[p] != '0); // see R3 R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host pin drivers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_space_flag_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      tx_space_flag_oe_o <= !tx_side_enable_n_i; // see R2
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_flag_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      rx_data_flag_oe_o <= !rx_side_enable_n_i; // see R4
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_data_oe_o <= 4'h0;
    end else if (clk_en_i) begin
      fifo_data_oe_o <= {4{!rx_side_enable_n_i && !rx_read_gate_n_i}} & ~byte_lane_enable_n_i; // see R11 R14
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_end_marker_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      frame_end_marker_oe_o <= !rx_side_enable_n_i && !rx_fifo_read_gate_n_i; // see R6
    end
  end

  // read word and frame end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_data_o <= '0;
      frame_end_marker_o <= 1'b0;
    end else if (clk_en_i && host_rd) begin
      fifo_data_o <= rd_masked;
      frame_end_marker_o <= rx_out_valid[fifo_port_select_i] && sel_rx_data[EOF_BIT]; // see R6 R8
    end
  end

  // space or data qualifier
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      space_or_data_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      if (host_rd) begin
        space_or_data_valid_o <= rx_out_valid[fifo_port_select_i]; // see R5
      end else if (!tx_side_enable_n_i && !tx_fifo_write_gate_n_i) begin
        space_or_data_valid_o <= tx_in_ready[fifo_port_select_i] && !tx_push[fifo_port_select_i]; // see R5
      end else if (rx_side_enable_n_i || rx_fifo_read_gate_n_i) begin
        space_or_data_valid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  assign addr_ok = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_THRESH)
                || (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_FRAMES);

  always_comb begin
    next_prdata = 32'h0;
    case (paddr_i)
      ADDR_CTRL: next_prdata[CTRL_NOFCS_BIT] = global_no_fcs;
      ADDR_THRESH: begin
        next_prdata[THR_TX_LSB +: LVL_W] = thr_tx;
        next_prdata[THR_RX_LSB +: LVL_W] = thr_rx;
      end
      ADDR_STATUS: begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          next_prdata[STAT_TX_LSB + LVL_W*p +: LVL_W] = tx_level[p];
          next_prdata[STAT_RX_LSB + LVL_W*p +: LVL_W] = rx_level[p];
        end
      end
      ADDR_FRAMES: begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          next_prdata[FRAMES_LSB + LVL_W*p +: LVL_W] = rx_frames[p];
        end
      end
      default: next_prdata = 32'h0;
    endcase
  end

  // one access cycle answer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
    end
  end

  // read data captured in setup
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0;
    end else if (clk_en_i && psel_i && !penable_i) begin
      prdata_o <= pwrite_i ? 32'h0 : next_prdata;
    end
  end

  // control register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_no_fcs <= CTRL_NOFCS_RST;
    end else if (clk_en_i && psel_i && penable_i && pready_o && pwrite_i && (paddr_i == ADDR_CTRL)) begin
      global_no_fcs <= pwdata_i[CTRL_NOFCS_BIT]; // see R10
    end
  end

  // threshold register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_tx <= THR_TX_RST;
      thr_rx <= THR_RX_RST;
    end else if (clk_en_i && psel_i && penable_i && pready_o && pwrite_i && (paddr_i == ADDR_THRESH)) begin
      thr_tx <= pwdata_i[THR_TX_LSB +: LVL_W]; // see R17
      thr_rx <= pwdata_i[THR_RX_LSB +: LVL_W]; // see R17
    end
  end
endmodule

// ==== hw/mfh_pkg.sv ====
// constants shared by the multiport fifo host port
package mfh_pkg;
  localparam int NUM_PORTS = 4;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int LVL_W = 3;
  localparam int EOF_BIT = 32;
  localparam int NOFCS_BIT = 33;
  localparam int TX_W = 34;
  localparam int RX_W = 33;
  localparam logic [LVL_W-1:0] FIFO_SLOTS = 3'h5;

  // apb register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FRAMES = 8'h0C;

  // field positions
  localparam int CTRL_NOFCS_BIT = 4;
  localparam int THR_TX_LSB = 0;
  localparam int THR_RX_LSB = 8;
  localparam int STAT_TX_LSB = 0;
  localparam int STAT_RX_LSB = 12;
  localparam int FRAMES_LSB = 0;

  // reset values
  localparam logic CTRL_NOFCS_RST = 1'b0;
  localparam logic [LVL_W-1:0] THR_TX_RST = 3'h1;
  localparam logic [LVL_W-1:0] THR_RX_RST = 3'h1;
endpackage

// ==== test/mfh_host_port_properties.sv ====
// pin level assertions for the host fifo port
`timescale 1ns/100ps
module mfh_host_port_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tx_side_enable_n_i,
  input wire logic rx_side_enable_n_i,
  input wire logic rx_read_gate_n_i,
  input wire logic rx_fifo_read_gate_n_i,
  input wire logic fifo_strobe_clock_i,
  input wire logic [3:0] byte_lane_enable_n_i,
  input wire logic [31:0] fifo_data_o,
  input wire logic [3:0] fifo_data_oe_o,
  input wire logic frame_end_marker_o,
  input wire logic frame_end_marker_oe_o,
  input wire logic tx_space_flag_oe_o,
  input wire logic rx_data_flag_oe_o,
  input wire logic space_or_data_valid_o,
  input wire logic [3:0] mac_tx_valid_o,
  input wire logic [3:0] mac_tx_ready_i
);
  logic [1:0] up;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up <= 2'h0;
    end else begin
      up <= {up[0] & clk_en_i, clk_en_i};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_tx_flag_drive: assert property (up[0] |-> tx_space_flag_oe_o == !$past(tx_side_enable_n_i))
    else $error("tx flag drive wrong");
  a_rx_flag_drive: assert property (up[0] |-> rx_data_flag_oe_o == !$past(rx_side_enable_n_i))
    else $error("rx flag drive wrong");
  a_data_bus_drive: assert property (up[0] |-> fifo_data_oe_o == ({4{!$past(rx_side_enable_n_i) &&
    !$past(rx_read_gate_n_i)}} & ~$past(byte_lane_enable_n_i))) else $error("data bus drive wrong");
  a_eof_drive: assert property (up[0] && frame_end_marker_oe_o |-> !$past(rx_side_enable_n_i))
    else $error("eof driven outside reads");
  a_read_hold: assert property (up[1] && !($past(fifo_strobe_clock_i) && !$past(fifo_strobe_clock_i, 2) &&
    !$past(rx_side_enable_n_i) && !$past(rx_fifo_read_gate_n_i)) |-> $stable({fifo_data_o, frame_end_marker_o}))
    else $error("read data moved without strobe");
  a_qual_idle: assert property (up[1] && $past(tx_side_enable_n_i && rx_side_enable_n_i) &&
    $past(tx_side_enable_n_i && rx_side_enable_n_i, 2) |-> !space_or_data_valid_o) else $error("qualifier idle");
  a_apb_answer: assert property (psel_i && !penable_i |=> pready_o) else $error("no apb answer");
  a_apb_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
  a_apb_err: assert property (pslverr_o |-> pready_o) else $error("error without pready");
  a_mac_hold: assert property (up[0] |-> (mac_tx_valid_o & $past(mac_tx_valid_o & ~mac_tx_ready_i)) ==
    $past(mac_tx_valid_o & ~mac_tx_ready_i)) else $error("tx word dropped");
endmodule
bind mfh_host_port mfh_host_port_chk chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .tx_side_enable_n_i(tx_side_enable_n_i), .rx_side_enable_n_i(rx_side_enable_n_i),
  .rx_read_gate_n_i(rx_read_gate_n_i), .rx_fifo_read_gate_n_i(rx_fifo_read_gate_n_i),
  .fifo_strobe_clock_i(fifo_strobe_clock_i), .byte_lane_enable_n_i(byte_lane_enable_n_i),
  .fifo_data_o(fifo_data_o), .fifo_data_oe_o(fifo_data_oe_o), .frame_end_marker_o(frame_end_marker_o),
  .frame_end_marker_oe_o(frame_end_marker_oe_o), .tx_space_flag_oe_o(tx_space_flag_oe_o),
  .rx_data_flag_oe_o(rx_data_flag_oe_o), .space_or_data_valid_o(space_or_data_valid_o),
  .mac_tx_valid_o(mac_tx_valid_o), .mac_tx_ready_i(mac_tx_ready_i));

// ==== test/mfh_mac_model.sv ====
// mac side partner: sinks tx words, sources rx frames
`timescale 1ns/100ps
module mfh_mac_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic [127:0] tx_data_i,
  input wire logic [3:0] tx_eof_i,
  input wire logic [3:0] tx_no_fcs_i,
  input wire logic [3:0] tx_valid_i,
  output logic [3:0] tx_ready_o,
  output logic [127:0] rx_data_o,
  output logic [3:0] rx_eof_o,
  output logic [3:0] rx_valid_o,
  input wire logic [3:0] rx_ready_i
);
  logic [33:0] got[4][$];
  int n[4];
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      n = '{0, 0, 0, 0};
      tx_ready_o <= 4'h0;
      rx_valid_o <= 4'h0;
      rx_eof_o <= 4'h0;
      rx_data_o <= '0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        logic v;
        if (tx_valid_i[p] && tx_ready_o[p]) begin
          got[p].push_back({tx_no_fcs_i[p], tx_eof_i[p], tx_data_i[32*p+:32]});
        end
        tx_ready_o[p] <= !stall_i && $urandom_range(1);
        if (rx_valid_o[p] && rx_ready_i[p]) begin
          n[p]++;
        end
        if (!rx_valid_o[p] || rx_ready_i[p]) begin
          v = n[p] < 6 && $urandom_range(1);
          rx_valid_o[p] <= v;
          rx_eof_o[p] <= v && n[p] % 3 == 2;
          rx_data_o[32*p+:32] <= (32'hC0DE0000 | (p << 8) | n[p]) ^ {32{!v}};
        end
      end
    end
  end
endmodule

// ==== test/multiport_fifo_host_interface_test.sv ====
// random and corner stimulus for the host fifo port
`timescale 1ns/100ps
module multiport_fifo_host_interface_test;
  import mfh_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, stall = 1, rerr, ce = 1;
  logic tx_en_n = 1, rx_en_n = 1, rd_gate_n = 1, rd_n = 1, wr_n = 1, strobe = 0, skip = 0, eof_in = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, din = 0, dout, rdat;
  logic [1:0] sel = 0;
  logic [3:0] be_n = 0, doe, txf, rxf, txv, txr, txe, txn, rxv, rxe, rxr;
  logic eof_o, eof_oe, txf_oe, rxf_oe, sdv;
  logic [127:0] txd, rxd;
  int miscompares = 0, checks = 0;
  mfh_host_port uut (.sys_clk_i(clk), .rst_i(rst), .clk_en_i(ce), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .tx_side_enable_n_i(tx_en_n), .rx_side_enable_n_i(rx_en_n), .rx_read_gate_n_i(rd_gate_n),
    .rx_fifo_read_gate_n_i(rd_n), .tx_fifo_write_gate_n_i(wr_n), .fifo_strobe_clock_i(strobe),
    .fifo_port_select_i(sel), .byte_lane_enable_n_i(be_n), .skip_fcs_this_frame_i(skip), .fifo_data_i(din),
    .fifo_data_o(dout), .fifo_data_oe_o(doe), .frame_end_marker_i(eof_in), .frame_end_marker_o(eof_o),
    .frame_end_marker_oe_o(eof_oe), .tx_space_flag_o(txf), .tx_space_flag_oe_o(txf_oe), .rx_data_flag_o(rxf),
    .rx_data_flag_oe_o(rxf_oe), .space_or_data_valid_o(sdv), .mac_tx_data_o(txd), .mac_tx_eof_o(txe),
    .mac_tx_no_fcs_o(txn), .mac_tx_valid_o(txv), .mac_tx_ready_i(txr), .mac_rx_data_i(rxd),
    .mac_rx_eof_i(rxe), .mac_rx_valid_i(rxv), .mac_rx_ready_o(rxr));
  mfh_mac_model mac (.clk_i(clk), .rst_i(rst), .stall_i(stall), .tx_data_i(txd), .tx_eof_i(txe),
    .tx_no_fcs_i(txn), .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_eof_o(rxe), .rx_valid_o(rxv),
    .rx_ready_i(rxr));
  ////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  function logic [31:0] lanes(input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      lanes[8*i+:8] = {8{!b[i]}};
    end
  endfunction
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task xfer(input logic w, input logic [1:0] p, input logic [31:0] d, input logic e, input logic s,
    input logic [3:0] b);
    @(posedge clk);
    tx_en_n <= !w;
    wr_n <= !w;
    rx_en_n <= w;
    rd_n <= w;
    rd_gate_n <= w;
    sel <= p;
    din <= w ? d : ~d;
    eof_in <= e;
    skip <= s;
    be_n <= b;
    @(posedge clk);
    strobe <= 1;
    @(posedge clk);
    strobe <= 0;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200us;
    miscompares++;
    stop_test;
  end
  initial begin
    logic [31:0] w[6];
    logic [3:0] be;
    void'($urandom(32'hD669));
    repeat (20) @(posedge clk);
    rst <= 0;
    apb(0, ADDR_CTRL, 0);
    chk(rdat, 0);
    apb(0, ADDR_THRESH, 0);
    chk(rdat, (THR_RX_RST << THR_RX_LSB) | (THR_TX_RST << THR_TX_LSB));
    apb(1, 8'h10, '1);
    chk(rerr, 1);
    apb(1, ADDR_THRESH, 32'h705);
    for (int i = 0; i < 6; i++) begin
      w[i] = $urandom;
      xfer(1, 1, w[i], i == 4, i == 2, 4'h0);
    end
    repeat (3) @(posedge clk);
    #1;
    chk(txf, 4'hD);
    chk(sdv, 0);
    chk({doe, eof_oe, rxf_oe, txf_oe}, 7'h01);
    apb(0, ADDR_STATUS, 0);
    chk(rdat[STAT_TX_LSB+3+:3], FIFO_SLOTS);
    stall <= 0;
    repeat (60) @(posedge clk);
    chk(mac.got[1].size(), 5);
    for (int i = 0; i < 5; i++) begin
      chk(mac.got[1].pop_front(), {i >= 2, i == 4, w[i]});
    end
    xfer(1, 1, w[5], 1, 0, 4'h0);
    repeat (20) @(posedge clk);
    chk(mac.got[1].pop_front(), {2'h1, w[5]});
    apb(1, ADDR_CTRL, 1 << CTRL_NOFCS_BIT);
    for (int p = 0; p < 4; p++) begin
      w[p] = $urandom;
      be = $urandom;
      xfer(1, p, w[p], 1, 0, be);
      repeat (20) @(posedge clk);
      #1;
      chk(mac.got[p].pop_front(), {2'h3, w[p] & lanes(be)});
    end
    for (int p = 0; p < 4; p++) begin
      chk(rxf[p], 1);
      for (int k = 0; k < 7; k++) begin
        be = $urandom;
        xfer(0, p, $urandom, 0, 0, be);
        chk(sdv, k < 6);
        chk({doe, eof_oe, rxf_oe, txf_oe}, {~be, 3'b110});
        if (k < 6) begin
          chk({eof_o, dout}, {k % 3 == 2, (32'hC0DE0000 | (p << 8) | k) & lanes(be)});
        end
      end
      repeat (2) @(posedge clk);
      #1;
      chk(rxf, 4'(4'hF << (p + 1)));
    end
    @(posedge clk);
    ce <= 0;
    xfer(1, 0, w[0], 1, 1, 4'h0);
    @(posedge clk);
    ce <= 1;
    repeat (3) @(posedge clk);
    #1;
    chk(txv, 4'h0);
    apb(0, ADDR_STATUS, 0);
    chk(rdat, 0);
    stop_test;
  end
endmodule
